// >>> hdl/rpmc_consts.svh
// offsets, field positions, reset values and timing counts of the pll modulation config block
`ifndef RPMC_CONSTS_SVH
`define RPMC_CONSTS_SVH
`define RPMC_OFS_FZ_HIGH 8'h38
`define RPMC_OFS_FZ_LOW 8'h39
`define RPMC_OFS_D1_HIGH 8'h3a
`define RPMC_OFS_D1_LOW 8'h3b
`define RPMC_OFS_CTRL 8'h30
`define RPMC_CTRL_PAGE_BIT 0
`define RPMC_CTRL_SRST_BIT 1
`define RPMC_CTRL_DATA_BIT 2
`define RPMC_REG_RESET 8'h00
`define RPMC_FRAC_LSB 3
`define RPMC_POL_BIT 2
`define RPMC_CF_BIT 2
`define RPMC_MOD_BIT 1
`define RPMC_REF_CLOCK_OUTPUT_ENABLE_BIT 0
`define RPMC_INT_BASE 12
`define RPMC_INT_BAND_STEP 4
`define RPMC_FRAC_DEN 8192
`define RPMC_XTAL_KHZ 26000
`define RPMC_REF_KHZ 500
`define RPMC_REF_HALF_CYC_315 26
`define RPMC_REF_HALF_CYC_434 26
`endif

// >>> hdl/rpmc_pkg.sv
// types of the pll modulation config block
package rpmc_pkg;
	typedef enum logic [1:0] {
		RPMC_CODE_MANCH = 2'b00,
		RPMC_CODE_BIPH = 2'b01,
		RPMC_CODE_NRZ = 2'b10,
		RPMC_CODE_DIRECT = 2'b11
	} rpmc_code_type;
	typedef struct packed {
		logic [12:0] fz_frac;
		logic [12:0] d1_frac;
		logic data_polarity_invert;
		rpmc_code_type code;
		logic cf;
		logic fsk;
		logic ref_clock_output_enable;
	} rpmc_cfg_type;
endpackage

// >>> hdl/rpmc_cfg_if.sv
// configuration carrier between register bank and reference divider
`timescale 1ns/1ns
interface rpmc_cfg_if;
	import rpmc_pkg::*;
	logic ref_en;
	logic band;
	logic ref_tick;
	modport bank (output ref_en, output band, input ref_tick);
	modport div (input ref_en, input band, output ref_tick);
endinterface

// >>> hdl/rpmc_ref_div.sv
// reference clock divider producing the 500 khz reference toggle from the crystal clock
`timescale 1ns/1ns
`include "rpmc_consts.svh"
module rpmc_ref_div
	import rpmc_pkg::*;
#(
	parameter int HALF_315 = `RPMC_REF_HALF_CYC_315,
	parameter int HALF_434 = `RPMC_REF_HALF_CYC_434
) (
	input wire logic clk,
	input wire logic rst_n,
	rpmc_cfg_if.div cfg
);
	if (HALF_315 < 1 || HALF_434 < 1 || HALF_315 > 256 || HALF_434 > 256) begin : g_bad_half
		$error("divider half period out of range");
	end
	logic [7:0] cnt_r;
	logic [7:0] lim;
	// band picks the divider so the reference frequency matches either band
	assign lim = cfg.band ? 8'(HALF_434 - 1) : 8'(HALF_315 - 1);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			cfg.ref_tick <= 1'b0;
		end else if (!cfg.ref_en) begin
			cnt_r <= 8'h00;
			cfg.ref_tick <= 1'b0;
		end else begin
			cfg.ref_tick <= (cnt_r >= lim);
			cnt_r <= (cnt_r >= lim) ? 8'h00 : cnt_r + 8'h01;
		end
	end
endmodule

// >>> hdl/rpmc_top.sv
// register bank and modulation control for the rf transmit pll
//
// Summary of operation
// - the four pll registers respond only while page select is zero
// - fsk data zero uses divider base plus zero fraction over 8192
// - data one uses divider base plus one fraction over 8192
// - soft reset clears fractions, polarity, encoding, band and modulation fields
// - polarity bit inverts nrz, direct bit and both code polarities
// - encoding 00 manchester, 01 bi-phase, 10 nrz, 11 direct bit
// - buffered nrz sends buffer bits straight to rf_data at the bit rate; the pll drive follows them every clock
// - encoding 11 makes output follow software data bit after polarity
// - band bit zero selects 315 mhz setup, one selects 434 mhz
// - modulation bit zero selects on-off keying, one frequency-shift keying
// - reference enable gates the 500 khz reference clock to reference_clock_out
// - band bit chooses the reference divider to keep 500 khz
// - page select in a separate control register chooses the shared page
`timescale 1ns/1ns
`include "rpmc_consts.svh"
module rpmc_top
	import rpmc_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic buf_bit,
	input wire logic bit_tick,
	input wire logic half_tick,
	output logic [13:0] pll_int_frac_hi,
	output logic [12:0] pll_frac,
	output logic [4:0] pll_int,
	output logic carrier_on,
	output logic rf_data,
	output logic band_434,
	output logic reference_clock_out
);
	// ----------------------------------------
	// reset synchroniser
	// ----------------------------------------
	logic rst_s1_r, rst_n_r;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	rpmc_cfg_type cfg_r;
	logic page_r, data_bit_r, srst;
	function automatic logic in_page0(input logic [7:0] a, input logic pg);
		in_page0 = !pg && (a >= `RPMC_OFS_FZ_HIGH) && (a <= `RPMC_OFS_D1_LOW);
	endfunction
	// one-cycle soft reset pulse; the bit itself never holds, so reads show zero
	assign srst = wr && addr == `RPMC_OFS_CTRL && wdata[`RPMC_CTRL_SRST_BIT];

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			page_r <= 1'b0;
			data_bit_r <= 1'b0;
		end else if (wr && addr == `RPMC_OFS_CTRL) begin
			page_r <= wdata[`RPMC_CTRL_PAGE_BIT];
			data_bit_r <= wdata[`RPMC_CTRL_DATA_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cfg_r <= '0;
		end else if (srst) begin
			cfg_r <= '0;
		end else if (wr && in_page0(addr, page_r)) begin
			unique case (addr)
				`RPMC_OFS_FZ_HIGH: cfg_r.fz_frac[12:5] <= wdata;
				`RPMC_OFS_FZ_LOW: begin
					cfg_r.fz_frac[4:0] <= wdata[7:`RPMC_FRAC_LSB];
					cfg_r.data_polarity_invert <= wdata[`RPMC_POL_BIT];
					cfg_r.code <= rpmc_code_type'(wdata[1:0]);
				end
				`RPMC_OFS_D1_HIGH: cfg_r.d1_frac[12:5] <= wdata;
				default: begin
					cfg_r.d1_frac[4:0] <= wdata[7:`RPMC_FRAC_LSB];
					cfg_r.cf <= wdata[`RPMC_CF_BIT];
					cfg_r.fsk <= wdata[`RPMC_MOD_BIT];
					cfg_r.ref_clock_output_enable <= wdata[`RPMC_REF_CLOCK_OUTPUT_ENABLE_BIT];
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata <= `RPMC_REG_RESET;
		end else if (rd && in_page0(addr, page_r)) begin
			unique case (addr)
				`RPMC_OFS_FZ_HIGH: rdata <= cfg_r.fz_frac[12:5];
				`RPMC_OFS_FZ_LOW: rdata <= {cfg_r.fz_frac[4:0], cfg_r.data_polarity_invert, cfg_r.code};
				`RPMC_OFS_D1_HIGH: rdata <= cfg_r.d1_frac[12:5];
				default: rdata <= {cfg_r.d1_frac[4:0], cfg_r.cf, cfg_r.fsk, cfg_r.ref_clock_output_enable};
			endcase
		end else if (rd && addr == `RPMC_OFS_CTRL) begin
			rdata <= {5'h00, data_bit_r, 1'b0, page_r};
		end else begin
			rdata <= `RPMC_REG_RESET;
		end
	end

	// ----------------------------------------
	// data encoding
	// ----------------------------------------
	logic enc_bit;
	always_comb begin
		unique case (cfg_r.code)
			RPMC_CODE_MANCH: enc_bit = buf_bit ^ half_tick;
			RPMC_CODE_BIPH: enc_bit = !(buf_bit ^ half_tick);
			RPMC_CODE_NRZ: enc_bit = buf_bit;
			RPMC_CODE_DIRECT: enc_bit = data_bit_r;
		endcase
	end
	// half_tick is the second half of a bit cell; manchester and bi-phase mixing relies on software doubling the bit rate
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rf_data <= 1'b0;
		end else if (bit_tick || cfg_r.code == RPMC_CODE_DIRECT || cfg_r.code != RPMC_CODE_NRZ) begin
			rf_data <= enc_bit ^ cfg_r.data_polarity_invert;
		end
	end

	// ----------------------------------------
	// pll drive
	// ----------------------------------------
	logic sym;
	assign sym = enc_bit ^ cfg_r.data_polarity_invert;
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pll_frac <= 13'h0000;
			pll_int <= 5'h00;
			carrier_on <= 1'b0;
			band_434 <= 1'b0;
			pll_int_frac_hi <= 14'h0000;
		end else begin
			pll_int <= 5'(`RPMC_INT_BASE + (cfg_r.cf ? `RPMC_INT_BAND_STEP : 0));
			band_434 <= cfg_r.cf;
			pll_frac <= (cfg_r.fsk && !sym) ? cfg_r.fz_frac : cfg_r.d1_frac;
			carrier_on <= cfg_r.fsk || sym;
			pll_int_frac_hi <= {pll_int, pll_frac[12:4]};
		end
	end

	// ----------------------------------------
	// reference clock
	// ----------------------------------------
	rpmc_cfg_if cif();
	assign cif.ref_en = cfg_r.ref_clock_output_enable;
	assign cif.band = cfg_r.cf;
	rpmc_ref_div u_div (
		.clk(mclk),
		.rst_n(rst_n_r),
		.cfg(cif.div)
	);
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reference_clock_out <= 1'b0;
		end else if (!cfg_r.ref_clock_output_enable) begin
			reference_clock_out <= 1'b0;
		end else if (cif.ref_tick) begin
			reference_clock_out <= !reference_clock_out;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	page_gate_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		rd && page_r && addr == `RPMC_OFS_FZ_HIGH |=> rdata == 8'h00) else $error("page one read leaked");
	soft_clear_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		srst |=> cfg_r == '0) else $error("soft reset did not clear");
	fsk_zero_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		cfg_r.fsk && !sym && !srst && !wr |=> pll_frac == $past(cfg_r.fz_frac)) else $error("fsk zero fraction");
	one_frac_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		sym && !wr |=> pll_frac == $past(cfg_r.d1_frac)) else $error("data one fraction");
	band_int_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		!wr && !srst ##1 !wr |=> pll_int == (band_434 ? 5'd16 : 5'd12)) else $error("integer part wrong");
	direct_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		cfg_r.code == RPMC_CODE_DIRECT && !wr |=> rf_data == ($past(data_bit_r) ^ $past(cfg_r.data_polarity_invert)))
		else $error("direct bit wrong");
	ook_gate_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		!cfg_r.fsk && !sym && !wr |=> !carrier_on) else $error("ook carrier on for zero");
	ref_off_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		!cfg_r.ref_clock_output_enable |=> !reference_clock_out) else $error("reference runs while disabled");
	ctrl_read_a: assert property (@(posedge mclk) disable iff (!rst_n_r)
		rd && addr == `RPMC_OFS_CTRL |=> !rdata[`RPMC_CTRL_SRST_BIT]) else $error("reset bit read as one");
	fsk_c: cover property (@(posedge mclk) disable iff (!rst_n_r) cfg_r.fsk && !sym);
	ref_c: cover property (@(posedge mclk) disable iff (!rst_n_r) $rose(reference_clock_out));
	srst_c: cover property (@(posedge mclk) disable iff (!rst_n_r) srst);
endmodule

// >>> dv/rpmc_rf_model.sv
// behavioural model of the rf pll that reports the divider ratio it is told to lock to
`timescale 1ns/1ns
module rpmc_rf_model (
	input wire logic mclk,
	input wire logic [4:0] pll_int,
	input wire logic [12:0] pll_frac,
	input wire logic carrier_on,
	output logic [17:0] ratio_q
);
	// ratio in 1/8192 steps; zero while the pa is off so a stale fraction cannot pass
	always_ff @(posedge mclk) begin
		ratio_q <= carrier_on ? {pll_int, pll_frac} : 18'h0_0000;
	end
endmodule

// >>> dv/rpmc_top_tb_top.sv
// self-checking bench of the pll modulation config block
`timescale 1ns/1ns
module rpmc_top_tb_top;
	import rpmc_pkg::*;
	logic mclk, resetn, wr, rd, buf_bit, bit_tick, half_tick, carrier_on, rf_data, band_434, reference_clock_out;
	logic [7:0] addr, wdata, rdata;
	logic [13:0] pll_int_frac_hi;
	logic [12:0] pll_frac;
	logic [4:0] pll_int;
	logic [17:0] ratio_q;
	int n_mismatch = 0;
	int n_tests = 0;
	rpmc_top uut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.buf_bit(buf_bit), .bit_tick(bit_tick), .half_tick(half_tick), .pll_int_frac_hi(pll_int_frac_hi),
		.pll_frac(pll_frac), .pll_int(pll_int), .carrier_on(carrier_on), .rf_data(rf_data),
		.band_434(band_434), .reference_clock_out(reference_clock_out));
	rpmc_rf_model pll (.mclk(mclk), .pll_int(pll_int), .pll_frac(pll_frac), .carrier_on(carrier_on),
		.ratio_q(ratio_q));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk({10'h000, rdata}, {10'h000, exp});
	endtask
	task automatic settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	// counts reference toggles; a window is used since the divider phase is free
	task automatic toggles(input int cyc, input int lo, input int hi);
		logic last;
		int n;
		n = 0;
		last = reference_clock_out;
		repeat (cyc) begin
			@(posedge mclk);
			#1 if (reference_clock_out !== last) n++;
			last = reference_clock_out;
		end
		chk(18'(n >= lo && n <= hi), 18'h0_0001);
	endtask
	task automatic t_zero;
		for (int a = 0; a < 4; a++) rd_chk(8'h38 + 8'(a), 8'h00);
		chk(pll_int, 5'h0c);
	endtask
	task automatic t_regs;
		wr_reg(8'h38, 8'hab);
		wr_reg(8'h39, 8'h5b);
		wr_reg(8'h3a, 8'hcd);
		wr_reg(8'h3b, 8'hb2);
		rd_chk(8'h38, 8'hab);
		rd_chk(8'h39, 8'h5b);
		rd_chk(8'h3a, 8'hcd);
		rd_chk(8'h3b, 8'hb2);
		wr_reg(8'h30, 8'h04);
		settle;
		chk(ratio_q, {5'h0c, 8'hcd, 5'h16});
		chk(pll_int_frac_hi, {5'h0c, 8'hcd, 1'b1});
		chk(rf_data, 1'b1);
		wr_reg(8'h30, 8'h00);
		settle;
		chk(ratio_q, {5'h0c, 8'hab, 5'h0b});
		wr_reg(8'h3b, 8'hb0);
		settle;
		chk(ratio_q, 18'h0_0000);
		wr_reg(8'h39, 8'h5f);
		settle;
		chk(ratio_q, {5'h0c, 8'hcd, 5'h16});
	endtask
	task automatic t_band;
		wr_reg(8'h3b, 8'hb6);
		wr_reg(8'h30, 8'h04);
		settle;
		chk(ratio_q, {5'h10, 8'hab, 5'h0b});
		chk(band_434, 1'b1);
	endtask
	task automatic t_page;
		wr_reg(8'h30, 8'h01);
		rd_chk(8'h38, 8'h00);
		wr_reg(8'h3a, 8'h11);
		rd_chk(8'h3a, 8'h00);
		wr_reg(8'h30, 8'h00);
		rd_chk(8'h3a, 8'hcd);
		rd_chk(8'h50, 8'h00);
	endtask
	task automatic t_codes;
		logic [1:0] c;
		logic p, b, h, e;
		for (int i = 0; i < 24; i++) begin
			{c, p, b, h} = 5'(i);
			wr_reg(8'h39, {5'h0b, p, c});
			buf_bit <= b;
			half_tick <= h;
			bit_tick <= 1'b1;
			@(posedge mclk);
			bit_tick <= 1'b0;
			settle;
			e = (c == 2'b10) ? b : (b ^ h ^ c[0]);
			chk(rf_data, e ^ p);
		end
	endtask
	task automatic t_ref;
		wr_reg(8'h3b, 8'h01);
		toggles(120, 3, 5);
		wr_reg(8'h3b, 8'h05);
		toggles(120, 3, 5);
		wr_reg(8'h3b, 8'h00);
		settle;
		toggles(60, 0, 0);
		chk(reference_clock_out, 1'b0);
	endtask
	task automatic t_srst;
		wr_reg(8'h3b, 8'h05);
		wr_reg(8'h30, 8'h02);
		settle;
		t_zero;
		rd_chk(8'h30, 8'h00);
		toggles(60, 0, 0);
	endtask
	task automatic results;
		$display("mismatches %0d tests %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		resetn = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		buf_bit = 1'b0;
		bit_tick = 1'b0;
		half_tick = 1'b0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		t_zero;
		t_regs;
		t_page;
		t_band;
		t_codes;
		t_ref;
		t_srst;
		results;
	end
	initial begin
		#2000000;
		n_mismatch++;
		results;
	end
endmodule
